// File: liu_control_interface_select.v
// control-interface select, host ports, interrupt pin and rx edge logic
`timescale 1ns/100ps
`include "liu_ctrl_defs.vh"

module liu_control_interface_select #(
   parameter SRC_W = 16
) (
   // clock and reset
   input  wire             i_clk,
   input  wire             i_rstn,
   // strap
   input  wire [1:0]       i_mode,
   // serial host port
   input  wire             i_cs_n,
   input  wire             i_sclk,
   input  wire             i_shift_edge_select,
   input  wire             i_serial_in,
   output wire             o_serial_out,
   // parallel host port
   input  wire [7:0]       i_ad,
   output wire [7:0]       o_ad,
   output wire             o_ad_oe,
   input  wire             i_ds_rd_n,
   input  wire             i_rw_wr_n,
   input  wire             i_ale_as,
   output wire             o_ack_rdy,
   // interrupt pin
   input  wire [SRC_W-1:0] i_irq_src,
   output wire             o_int,
   output wire             o_int_oe,
   // hardware mode pins
   input  wire             i_rx_clock_edge_select,
   input  wire [1:0]       i_line_path_mode,
   // receive path
   input  wire             i_rx_clk,
   input  wire             i_rx_pos,
   input  wire             i_rx_neg,
   output wire             o_rclk,
   output wire             o_rdp,
   output wire             o_rdn,
   output wire             o_dual_rail,
   output wire             o_ami,
   output wire             o_cdr_off,
   output wire             o_sw_mode
);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam SW = 23;
   wire [SW-1:0] async_in = {i_mode, i_cs_n, i_sclk, i_shift_edge_select,
      i_serial_in, i_ad, i_ds_rd_n, i_rw_wr_n, i_ale_as,
      i_rx_clock_edge_select, i_line_path_mode, i_rx_clk, i_rx_pos,
      i_rx_neg};
   reg  [SW-1:0] meta_reg;
   reg  [SW-1:0] sync_reg;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         // idle levels, so no false edge is seen after reset
         meta_reg <= `RST_SYNC_IDLE;
         sync_reg <= `RST_SYNC_IDLE;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   wire [1:0] mode_s  = sync_reg[22:21];
   wire       cs_s    = ~sync_reg[20];
   wire       sclk_s  = sync_reg[19];
   wire       esel_s  = sync_reg[18];
   wire       sdi_s   = sync_reg[17];
   wire [7:0] ad_s    = sync_reg[16:9];
   wire       ds_s    = sync_reg[8];
   wire       rw_s    = sync_reg[7];
   wire       ale_s   = sync_reg[6];
   wire       rsel_s  = sync_reg[5];
   wire [1:0] path_s  = sync_reg[4:3];
   wire       rclk_s  = sync_reg[2];
   wire       rpos_s  = sync_reg[1];
   wire       rneg_s  = sync_reg[0];

   // ----------------------------------------
   // strap capture after reset release
   // ----------------------------------------
   // held static, so one capture is enough and mid-run glitches are moot
   reg [1:0] settle_reg;
   reg [1:0] mode_reg;
   reg       mode_ok_reg;
   reg       sw_reg;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         settle_reg  <= 2'h0;
         mode_reg    <= `MODE_HW;
         mode_ok_reg <= 1'b0;
         sw_reg      <= 1'b0;
      end else if (!mode_ok_reg) begin
         settle_reg <= settle_reg + 2'h1;
         if (settle_reg == `STRAP_SETTLE) begin
            mode_reg    <= mode_s;
            mode_ok_reg <= 1'b1;
            sw_reg      <= (mode_s != `MODE_HW);
         end
      end
   end

   wire is_hw  = (mode_reg == `MODE_HW);
   wire is_ser = mode_ok_reg && (mode_reg == `MODE_SERIAL);
   wire is_pa  = mode_ok_reg && (mode_reg == `MODE_PAR_A);
   wire is_pb  = mode_ok_reg && (mode_reg == `MODE_PAR_B);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   reg  [7:0]       gcf_reg;
   reg  [7:0]       mask0_reg;
   reg  [7:0]       mask1_reg;
   reg  [SRC_W-1:0] stat_reg;
   wire             wr_en;
   wire [6:0]       wr_addr;
   wire [7:0]       wr_data;
   wire             rd_en;
   wire [6:0]       rd_addr;

   function [7:0] rd_mux;
      input [6:0] a;
      begin
         if (a == `OFS_GLOBAL_CONFIG)
            rd_mux = gcf_reg;
         else if (a == `OFS_IRQ_MASK_0)
            rd_mux = mask0_reg;
         else if (a == `OFS_IRQ_MASK_1)
            rd_mux = mask1_reg;
         else if (a == `OFS_IRQ_STATUS_0)
            rd_mux = stat_reg[7:0];
         else if (a == `OFS_IRQ_STATUS_1)
            rd_mux = stat_reg[15:8];
         else
            rd_mux = 8'h00;
      end
   endfunction

   // status is sticky; a read clears it but a new event wins the cycle
   reg [SRC_W-1:0] stat_clr;
   always @* begin
      stat_clr = {SRC_W{1'b0}};
      if (rd_en && rd_addr == `OFS_IRQ_STATUS_0)
         stat_clr[7:0] = 8'hff;
      if (rd_en && rd_addr == `OFS_IRQ_STATUS_1)
         stat_clr[15:8] = 8'hff;
   end

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gcf_reg   <= `RST_GLOBAL_CONFIG;
         mask0_reg <= `RST_IRQ_MASK;
         mask1_reg <= `RST_IRQ_MASK;
         stat_reg  <= {SRC_W{1'b0}};
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | i_irq_src;
         if (wr_en && wr_addr == `OFS_GLOBAL_CONFIG)
            gcf_reg <= wr_data;
         else if (wr_en && wr_addr == `OFS_IRQ_MASK_0)
            mask0_reg <= wr_data;
         else if (wr_en && wr_addr == `OFS_IRQ_MASK_1)
            mask1_reg <= wr_data;
      end
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   reg        sclk_d_reg;
   reg  [3:0] bit_reg;
   reg  [7:0] sin_reg;
   reg  [7:0] cmd_reg;
   reg  [7:0] sout_reg;
   reg        sdo_reg;
   wire       ser_on   = is_ser && cs_s;
   wire       sclk_up  = ser_on && sclk_s && !sclk_d_reg;
   wire       sclk_dn  = ser_on && !sclk_s && sclk_d_reg;
   wire       act_edge = esel_s ? sclk_dn : sclk_up;
   wire [7:0] sin_next = {sin_reg[6:0], sdi_s};
   wire       cmd_done = sclk_up && bit_reg == `SER_CMD_BITS;
   wire       ser_rd   = sin_next[`SER_READ_BIT];
   wire       ser_wr   = sclk_up && bit_reg == `SER_LAST_BIT
                         && !cmd_reg[`SER_READ_BIT];
   wire [7:0] ser_rdata = rd_mux(sin_next[6:0]);

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sclk_d_reg <= 1'b0;
         bit_reg    <= 4'h0;
         sin_reg    <= 8'h00;
         cmd_reg    <= 8'h00;
         sout_reg   <= 8'h00;
         sdo_reg    <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         if (!ser_on) begin
            bit_reg <= 4'h0;
         end else begin
            if (sclk_up) begin
               sin_reg <= sin_next;
               bit_reg <= bit_reg + 4'h1;
            end
            if (cmd_done) begin
               cmd_reg <= sin_next;
               if (ser_rd && !esel_s) begin
                  sdo_reg  <= ser_rdata[7];
                  sout_reg <= {ser_rdata[6:0], 1'b0};
               end else if (ser_rd) begin
                  sout_reg <= ser_rdata;
               end else begin
                  sout_reg <= 8'h00;
               end
            end else if (act_edge && bit_reg[3]) begin
               sdo_reg  <= sout_reg[7];
               sout_reg <= {sout_reg[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------
   // parallel engine
   // ----------------------------------------
   reg        ale_d_reg;
   reg  [6:0] paddr_reg;
   reg        act_d_reg;
   reg  [7:0] pdata_reg;
   reg        poe_reg;
   reg        ack_reg;
   wire       par_on = (is_pa || is_pb) && cs_s;
   // bus A: one data strobe plus read/write level; bus B: two strobes
   wire       p_rd   = par_on && (is_pa ? (!ds_s && rw_s) : !ds_s);
   wire       p_wr   = par_on && (is_pa ? (!ds_s && !rw_s) : !rw_s);
   wire       p_act  = p_rd || p_wr;
   wire       p_go   = p_act && !act_d_reg;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ale_d_reg <= 1'b0;
         paddr_reg <= 7'h00;
         act_d_reg <= 1'b0;
         pdata_reg <= 8'h00;
         poe_reg   <= 1'b0;
         ack_reg   <= 1'b1;
      end else begin
         ale_d_reg <= ale_s;
         act_d_reg <= p_act;
         if ((is_pa || is_pb) && cs_s && ale_d_reg && !ale_s)
            paddr_reg <= ad_s[6:0];
         if (p_go && p_rd)
            pdata_reg <= rd_mux(paddr_reg);
         poe_reg <= p_rd && act_d_reg;
         // bus A acknowledges low once the strobe is served
         // bus B shows ready low for one cycle only, the cycle after the access starts
         if (is_pa)
            ack_reg <= ~(p_act && act_d_reg);
         else
            ack_reg <= ~p_go;
      end
   end

   // ----------------------------------------
   // register access funnel
   // ----------------------------------------
   assign wr_en   = ser_wr || (p_go && p_wr);
   assign wr_addr = ser_wr ? cmd_reg[6:0] : paddr_reg;
   assign wr_data = ser_wr ? sin_next : ad_s;
   assign rd_en   = (cmd_done && ser_rd) || (p_go && p_rd);
   assign rd_addr = cmd_done ? sin_next[6:0] : paddr_reg;

   // ----------------------------------------
   // interrupt pin
   // ----------------------------------------
   reg        int_reg;
   reg        int_oe_reg;
   wire [1:0] style = gcf_reg[`GCF_INT_STYLE_MSB:`GCF_INT_STYLE_LSB];
   wire       irq   = !is_hw && mode_ok_reg &&
                      |(stat_reg & ~{mask1_reg, mask0_reg});

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         int_reg    <= 1'b1;
         int_oe_reg <= 1'b1;
      end else if (style == `INT_PP_HIGH) begin
         int_reg    <= irq;
         int_oe_reg <= 1'b1;
      end else if (style[1]) begin
         int_reg    <= 1'b0;
         int_oe_reg <= irq;
      end else begin
         int_reg    <= ~irq;
         int_oe_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // receive edge and path mode
   // ----------------------------------------
   reg        rclk_reg;
   reg        rdp_reg;
   reg        rdn_reg;
   reg  [2:0] path_reg;
   // software mode keeps the rising edge, since the edge-select pin is gated by is_hw
   wire       fall_sel = is_hw && rsel_s;
   wire       r_up     = rclk_s && !rclk_reg;
   wire       r_dn     = !rclk_s && rclk_reg;
   wire       r_act    = fall_sel ? r_dn : r_up;
   wire [1:0] path     = is_hw ? path_s : `PATH_SR_HDB3;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rclk_reg <= 1'b0;
         rdp_reg  <= 1'b0;
         rdn_reg  <= 1'b0;
         path_reg <= `RST_PATH_FLAGS;
      end else begin
         path_reg <= {path[1], path == `PATH_SR_AMI,
                      path == `PATH_SLICER};
         if (path == `PATH_SLICER)
            rclk_reg <= rpos_s ^ rneg_s;
         else
            rclk_reg <= rclk_s;
         if (r_act) begin
            rdp_reg <= rpos_s;
            rdn_reg <= path[1] ? rneg_s : 1'b0;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_serial_out = sdo_reg;
   assign o_ad         = pdata_reg;
   assign o_ad_oe      = poe_reg;
   assign o_ack_rdy    = ack_reg;
   assign o_int        = int_reg;
   assign o_int_oe     = int_oe_reg;
   assign o_rclk       = rclk_reg;
   assign o_rdp        = rdp_reg;
   assign o_rdn        = rdn_reg;
   assign o_dual_rail  = path_reg[2];
   assign o_ami        = path_reg[1];
   assign o_cdr_off    = path_reg[0];
   assign o_sw_mode    = sw_reg;

endmodule // liu_control_interface_select

// File: liu_ctrl_defs.vh
// constants for the control-interface front end
`ifndef LIU_CTRL_DEFS_VH
`define LIU_CTRL_DEFS_VH

// ----------------------------------------
// control-interface strap codes
// ----------------------------------------
`define MODE_HW        2'h0
`define MODE_SERIAL    2'h1
`define MODE_PAR_A     2'h2
`define MODE_PAR_B     2'h3

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_GLOBAL_CONFIG  7'h02
`define OFS_IRQ_MASK_0     7'h14
`define OFS_IRQ_MASK_1     7'h15
`define OFS_IRQ_STATUS_0   7'h19
`define OFS_IRQ_STATUS_1   7'h1a

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GCF_INT_STYLE_LSB  0
`define GCF_INT_STYLE_MSB  1
`define INT_PP_LOW         2'h0
`define INT_PP_HIGH        2'h1
`define INT_OPEN_DRAIN     2'h2
`define RST_GLOBAL_CONFIG  8'h00
`define RST_IRQ_MASK       8'hff
`define RST_IRQ_STATUS     8'h00
// select and strobes idle high, every other synced pin low
`define RST_SYNC_IDLE      23'h100180
`define RST_PATH_FLAGS     3'h0

// ----------------------------------------
// serial frame
// ----------------------------------------
`define SER_CMD_BITS       4'h7
`define SER_LAST_BIT       4'hf
`define SER_READ_BIT       7

// ----------------------------------------
// line path modes
// ----------------------------------------
`define PATH_SR_HDB3       2'h0
`define PATH_SR_AMI        2'h1
`define PATH_DR_CDR        2'h2
`define PATH_SLICER        2'h3

// ----------------------------------------
// strap settling after reset release
// ----------------------------------------
`define STRAP_SETTLE       2'h3

`endif

// File: liu_ctrl_properties.sv
// assertion checker for the control-interface front end
`timescale 1ns/100ps
module liu_ctrl_checker (
   // clock, reset and straps
   input wire       i_clk, i_rstn,
   input wire [1:0] i_mode, i_line_path_mode,
   // host and hardware pins
   input wire       i_cs_n, i_sclk, i_shift_edge_select,
   input wire       i_rx_clock_edge_select,
   // device outputs
   input wire       o_serial_out, o_ad_oe, o_ack_rdy, o_int, o_int_oe,
   input wire       o_rclk, o_rdp, o_dual_rail, o_ami, o_cdr_off, o_sw_mode
);
   reg       sclk_reg;
   reg [3:0] since_reg;
   reg [3:0] up_reg;
   wire      act = i_shift_edge_select ? (sclk_reg & ~i_sclk)
                                       : (~sclk_reg & i_sclk);
   // ----------------------------------------
   // cycles since the active shift edge and since reset
   // ----------------------------------------
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sclk_reg  <= 1'b0;
         since_reg <= 4'hf;
         up_reg    <= 4'h0;
      end else begin
         sclk_reg  <= i_sclk;
         since_reg <= act ? 4'h0 : since_reg + {3'h0, since_reg != 4'hf};
         up_reg    <= up_reg + {3'h0, up_reg != 4'hf};
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sw_strap_a: assert property (
      o_sw_mode |-> i_mode != 2'h0) else $error("sw mode on hw strap");
   hw_irq_idle_a: assert property (
      !o_sw_mode |-> o_int && o_int_oe) else $error("irq active in hw mode");
   out_edge_a: assert property (
      $changed(o_serial_out) |-> since_reg < 4'h6)
      else $error("serial out moved off its edge");
   ad_oe_mode_a: assert property (
      o_ad_oe |-> i_mode[1] && o_sw_mode) else $error("bus driven wrongly");
   ack_sel_a: assert property (
      !o_ack_rdy |-> i_mode[1] && !i_cs_n) else $error("ack without select");
   rdy_pulse_a: assert property (
      i_mode == 2'h3 && $fell(o_ack_rdy) |=> o_ack_rdy)
      else $error("ready low too long");
   rx_edge_a: assert property (
      i_mode == 2'h0 && i_line_path_mode != 2'h3 && $changed(o_rdp)
      |-> (i_rx_clock_edge_select ? $fell(o_rclk) : $rose(o_rclk)))
      else $error("rx data off its clock edge");
   path_dec_a: assert property (
      (up_reg == 4'hf && i_mode == 2'h0 && $stable(i_line_path_mode))[*5]
      |-> o_dual_rail == i_line_path_mode[1]
      && o_ami == (i_line_path_mode == 2'h1)
      && o_cdr_off == (i_line_path_mode == 2'h3))
      else $error("path decode wrong");
endmodule // liu_ctrl_checker

bind liu_control_interface_select liu_ctrl_checker u_liu_ctrl_checker (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_mode(i_mode),
   .i_line_path_mode(i_line_path_mode), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
   .i_shift_edge_select(i_shift_edge_select),
   .i_rx_clock_edge_select(i_rx_clock_edge_select),
   .o_serial_out(o_serial_out), .o_ad_oe(o_ad_oe), .o_ack_rdy(o_ack_rdy),
   .o_int(o_int), .o_int_oe(o_int_oe), .o_rclk(o_rclk), .o_rdp(o_rdp),
   .o_dual_rail(o_dual_rail), .o_ami(o_ami), .o_cdr_off(o_cdr_off),
   .o_sw_mode(o_sw_mode));

// File: liu_host_model.sv
// host controller model for the serial and multiplexed parallel ports
`timescale 1ns/100ps
module liu_host_model (
   // clock and device answers
   input  wire       i_clk, i_sel, i_serial_out, i_ack, i_oe,
   input  wire [7:0] i_ad,
   // host-driven pins
   output reg        o_cs_n, o_sclk, o_ser_in, o_ds_rd_n, o_rw_wr_n, o_ale,
   output reg  [7:0] o_ad,
   output reg  [1:0] o_hs
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_ser_in = 1'b0;
      o_ds_rd_n = 1'b1;
      o_rw_wr_n = 1'b1;
      o_ale = 1'b0;
      o_ad = 8'h00;
      o_hs = 2'h0;
   end
   // ----------------------------------------
   // serial frame, shift clock 160 ns, still between frames
   // ----------------------------------------
   task ser(input wr, input [6:0] a, input [7:0] d, output [7:0] q);
      reg [15:0] f;
      integer    i;
      begin
         f = {~wr, a, d};
         q = 8'h00;
         @(negedge i_clk);
         o_cs_n = 1'b0;
         for (i = 15; i >= 0; i = i - 1) begin
            o_ser_in = f[i];
            repeat (8) @(negedge i_clk);
            o_sclk = 1'b1;
            // read data taken on the edge opposite the launching one
            if (i_sel && i < 8) q = {q[6:0], i_serial_out};
            repeat (8) @(negedge i_clk);
            if (!i_sel && i > 0 && i < 9) q = {q[6:0], i_serial_out};
            o_sclk = 1'b0;
         end
         repeat (4) @(negedge i_clk);
         o_cs_n = 1'b1;
         o_ser_in = ~o_ser_in;
         repeat (6) @(negedge i_clk);
      end
   endtask
   task par(input bus_a, input wr, input cs_n, input [6:0] a,
            input [7:0] d, output [7:0] q);
      begin
         @(negedge i_clk);
         o_cs_n = cs_n;
         o_ad = {1'b0, a};
         o_ale = 1'b1;
         o_rw_wr_n = bus_a ? ~wr : 1'b1;
         repeat (4) @(negedge i_clk);
         o_ale = 1'b0;
         repeat (5) @(negedge i_clk);
         // a read drives the inverted address, so the lines no longer hold the address
         o_ad = wr ? d : ~o_ad;
         if (bus_a || !wr) o_ds_rd_n = 1'b0;
         else o_rw_wr_n = 1'b0;
         repeat (8) @(negedge i_clk);
         q = i_ad;
         // handshake pins while the strobe is still low
         o_hs = {i_ack, i_oe};
         o_ds_rd_n = 1'b1;
         o_rw_wr_n = 1'b1;
         repeat (8) @(negedge i_clk);
         o_cs_n = 1'b1;
         o_ad = ~o_ad;
         repeat (4) @(negedge i_clk);
      end
   endtask
endmodule // liu_host_model

// File: tb_top.sv
// self-checking testbench for the control-interface front end
`timescale 1ns/100ps
`include "liu_ctrl_defs.vh"
`define CHK(nm, got, exp) begin \
   check_count = check_count + 1; \
   if ((got) !== (exp)) begin \
      errors = errors + 1; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
   end \
end
module tb_top;
   reg        i_clk, i_rstn, i_shift_edge_select, i_rx_clock_edge_select;
   reg        i_rx_clk, i_rx_pos, i_rx_neg;
   reg  [1:0] i_mode, i_line_path_mode;
   reg [15:0] i_irq_src, s;
   wire       i_cs_n, i_sclk, i_serial_in, i_ds_rd_n, i_rw_wr_n, i_ale_as;
   wire [7:0] i_ad, o_ad;
   wire       o_serial_out, o_ad_oe, o_ack_rdy, o_int, o_int_oe, o_rclk;
   wire       o_rdp, o_rdn, o_dual_rail, o_ami, o_cdr_off, o_sw_mode;
   wire [1:0] hs;
   reg  [7:0] q, b;
   reg  [6:0] ma, sa;
   reg  [2:0] e3;
   reg [31:0] seed;
   integer    errors, check_count, i, k, m;

   liu_control_interface_select u_liu_control_interface_select (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_mode(i_mode), .i_cs_n(i_cs_n),
      .i_sclk(i_sclk), .i_shift_edge_select(i_shift_edge_select),
      .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
      .i_ad(i_ad), .o_ad(o_ad), .o_ad_oe(o_ad_oe),
      .i_ds_rd_n(i_ds_rd_n), .i_rw_wr_n(i_rw_wr_n), .i_ale_as(i_ale_as),
      .o_ack_rdy(o_ack_rdy), .i_irq_src(i_irq_src), .o_int(o_int),
      .o_int_oe(o_int_oe),
      .i_rx_clock_edge_select(i_rx_clock_edge_select),
      .i_line_path_mode(i_line_path_mode), .i_rx_clk(i_rx_clk),
      .i_rx_pos(i_rx_pos), .i_rx_neg(i_rx_neg), .o_rclk(o_rclk),
      .o_rdp(o_rdp), .o_rdn(o_rdn), .o_dual_rail(o_dual_rail),
      .o_ami(o_ami), .o_cdr_off(o_cdr_off), .o_sw_mode(o_sw_mode));
   liu_host_model u_host (.i_clk(i_clk), .i_sel(i_shift_edge_select),
      .i_serial_out(o_serial_out), .i_ad(o_ad), .o_cs_n(i_cs_n),
      .i_ack(o_ack_rdy), .i_oe(o_ad_oe), .o_hs(hs),
      .o_sclk(i_sclk), .o_ser_in(i_serial_in), .o_ad(i_ad),
      .o_ds_rd_n(i_ds_rd_n), .o_rw_wr_n(i_rw_wr_n), .o_ale(i_ale_as));

   function [31:0] rnd(input [31:0] v);
      reg [31:0] x;
      begin
         x = v ^ (v << 13);
         x = x ^ (x >> 17);
         rnd = x ^ (x << 5);
      end
   endfunction
   function [1:0] pin_exp(input [1:0] st, input act);
      pin_exp = st == `INT_PP_HIGH ? {act, 1'b1} :
                st == `INT_PP_LOW ? {~act, 1'b1} : {1'b0, act};
   endfunction
   task chk_pin(input [1:0] st, input act);
      reg [1:0] e;
      begin
         e = pin_exp(st, act);
         `CHK("int_oe", o_int_oe, e[0]);
         if (e[0]) `CHK("int", o_int, e[1]);
      end
   endtask
   task reset_to(input [1:0] md);
      begin
         @(negedge i_clk);
         i_rstn = 1'b0;
         i_mode = md;
         repeat (16) @(negedge i_clk);
         i_rstn = 1'b1;
         repeat (10) @(negedge i_clk);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", check_count, errors);
         if (errors == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // generous bound, the run needs about a fifth of it
   initial begin
      repeat (40000) @(posedge i_clk);
      errors = errors + 1;
      summarize;
   end
   initial begin
      errors = 0;
      check_count = 0;
      seed = 32'd2729;
      i_rstn = 1'b0;
      i_mode = `MODE_SERIAL;
      i_shift_edge_select = 1'b0;
      i_rx_clock_edge_select = 1'b0;
      i_line_path_mode = 2'h0;
      {i_rx_clk, i_rx_pos, i_rx_neg} = 3'h0;
      i_irq_src = 16'h0000;
      reset_to(`MODE_SERIAL);
      `CHK("sw_mode", o_sw_mode, 1'b1);
      `CHK("sw path", ({o_dual_rail, o_ami, o_cdr_off}), 3'h0);
      u_host.ser(1'b0, `OFS_IRQ_MASK_1, 8'h00, q);
      `CHK("mask rst", q, `RST_IRQ_MASK);
      u_host.ser(1'b1, `OFS_IRQ_STATUS_0, 8'h5a, q);
      u_host.ser(1'b0, `OFS_IRQ_STATUS_0, 8'h00, q);
      `CHK("status ro", q, `RST_IRQ_STATUS);
      u_host.ser(1'b0, 7'h7f, 8'h00, q);
      `CHK("unmapped", q, 8'h00);
      for (m = 0; m < 2; m = m + 1) begin
         i_shift_edge_select = m[0];
         seed = rnd(seed);
         u_host.ser(1'b1, `OFS_GLOBAL_CONFIG, seed[7:0], q);
         u_host.ser(1'b0, `OFS_GLOBAL_CONFIG, 8'h00, q);
         `CHK("config", q, seed[7:0]);
      end
      for (m = 0; m < 3; m = m + 1) begin
         seed = rnd(seed);
         k = seed[3:0];
         s = 16'h0001 << k;
         ma = k < 8 ? `OFS_IRQ_MASK_0 : `OFS_IRQ_MASK_1;
         sa = k < 8 ? `OFS_IRQ_STATUS_0 : `OFS_IRQ_STATUS_1;
         b = k < 8 ? s[7:0] : s[15:8];
         u_host.ser(1'b1, `OFS_GLOBAL_CONFIG, m[7:0], q);
         // pass 0 unmasks only the chosen source, pass 1 masks it again
         for (i = 0; i < 2; i = i + 1) begin
            u_host.ser(1'b1, ma, i ? 8'hff : ~b, q);
            i_irq_src = s;
            repeat (2) @(negedge i_clk);
            i_irq_src = 16'h0000;
            repeat (4) @(negedge i_clk);
            chk_pin(m[1:0], i == 0);
            u_host.ser(1'b0, sa, 8'h00, q);
            `CHK("status", q, b);
            repeat (4) @(negedge i_clk);
            chk_pin(m[1:0], 1'b0);
         end
      end
      for (m = 2; m < 4; m = m + 1) begin
         reset_to(m[1:0]);
         u_host.par(m == 2, 1'b0, 1'b0, `OFS_IRQ_MASK_0, 8'h00, q);
         `CHK("par rst", q, `RST_IRQ_MASK);
         `CHK("rd hs", hs, ({m == 3, 1'b1}));
         seed = rnd(seed);
         u_host.par(m == 2, 1'b1, 1'b0, `OFS_IRQ_MASK_1, seed[7:0], q);
         `CHK("wr hs", hs, ({m == 3, 1'b0}));
         u_host.par(m == 2, 1'b1, 1'b1, `OFS_IRQ_MASK_1, ~seed[7:0], q);
         `CHK("idle hs", hs, 2'h2);
         u_host.par(m == 2, 1'b0, 1'b0, `OFS_IRQ_MASK_1, 8'h00, q);
         `CHK("par rw", q, seed[7:0]);
         `CHK("rd hs", hs, ({m == 3, 1'b1}));
      end
      reset_to(`MODE_HW);
      `CHK("hw mode", o_sw_mode, 1'b0);
      for (m = 0; m < 4; m = m + 1) begin
         i_line_path_mode = m[1:0];
         i_rx_clock_edge_select = m[0];
         repeat (8) @(negedge i_clk);
         e3 = {m[1], m == 1, m == 3};
         `CHK("path", ({o_dual_rail, o_ami, o_cdr_off}), e3);
         // link clock of 160 ns, data moves on its falling edge
         for (i = 0; i < 32; i = i + 1) begin
            seed = rnd(seed);
            i_rx_clk = ~i_rx_clk;
            if (!i_rx_clk) {i_rx_pos, i_rx_neg} = seed[1:0];
            repeat (8) @(negedge i_clk);
            `CHK("rclk", o_rclk, (m == 3 ? i_rx_pos ^ i_rx_neg : i_rx_clk));
            if (m < 3 && i_rx_clk != m[0]) begin
               `CHK("rdp", o_rdp, i_rx_pos);
               `CHK("rdn", o_rdn, (m[1] & i_rx_neg));
            end
         end
      end
      summarize;
   end
endmodule // tb_top
